// *** shared/cas_pkg.sv ***
package cas_pkg;
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [15:0] STK_RST    = 16'h0000;
  localparam logic [15:0] IO_BASE    = 16'h0020;
  localparam logic [15:0] SRAM_BASE  = 16'h0060;
  localparam logic [5:0]  IO_SPL     = 6'h3d;
  localparam logic [5:0]  IO_SPH     = 6'h3e;
  localparam logic [5:0]  IO_STATUS  = 6'h3f;
  localparam logic [4:0]  PTR_X_LO   = 5'h1a;
  localparam logic [4:0]  PTR_Z_LO   = 5'h1e;
  localparam logic [3:0]  OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3;
  localparam logic [3:0]  OP_AND = 4'h4, OP_OR = 4'h5, OP_EOR = 4'h6, OP_MOV = 4'h7;
  localparam logic [3:0]  OP_SUBI = 4'h8, OP_ORI = 4'h9, OP_ANDI = 4'ha, OP_LDI = 4'hb;
  localparam logic [3:0]  OP_MISC = 4'hc, OP_BR = 4'hd, OP_MEM = 4'he, OP_IO = 4'hf;
  localparam logic [3:0]  MS_COM = 4'h0, MS_NEG = 4'h1, MS_INC = 4'h2, MS_DEC = 4'h3;
  localparam logic [3:0]  MS_LSR = 4'h4, MS_ROR = 4'h5, MS_ASR = 4'h6, MS_SWAP = 4'h7;
  localparam logic [3:0]  MS_BSTORE = 4'h8, MS_BLOAD = 4'h9, MS_GION = 4'ha, MS_GIOFF = 4'hb;
  localparam logic [3:0]  MS_RET = 4'hc, MS_IRET = 4'hd, MS_CALL = 4'he;
  localparam logic [1:0]  LD_INT = 2'd0, LD_IO = 2'd1, LD_SRAM = 2'd2;
  typedef enum logic [3:0] {
    ST_EXEC, ST_LD_W, ST_LPM_A, ST_LPM_D, ST_CALL_T, ST_PUSH_L, ST_PUSH_H,
    ST_POP_H, ST_POP_L, ST_POP_D, ST_POP_F
  } cas_state_type;
endpackage

// *** core/cas_core.sv ***
`timescale 1ns/1ps
module cas_core
  import cas_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int NIRQ = 16
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  output wire logic [PC_W-1:0] pm_addr,
  input  wire logic [15:0]     pm_data,
  output wire logic [15:0]     dm_addr,
  output wire logic [7:0]      dm_wdata,
  output wire logic            dm_we,
  output wire logic            dm_re,
  input  wire logic [7:0]      dm_rdata,
  output wire logic [5:0]      io_addr,
  output wire logic [7:0]      io_wdata,
  output wire logic            io_we,
  output wire logic            io_re,
  input  wire logic [7:0]      io_rdata,
  input  wire logic [NIRQ-1:0] irq_req,
  output logic                 irq_ack,
  output logic [7:0]           irq_id,
  input  wire logic [7:0]      hst_addr,
  input  wire logic [7:0]      hst_wdata,
  input  wire logic            hst_wr,
  input  wire logic            hst_rd,
  output logic [7:0]           hst_rdata,
  output wire logic [7:0]      status_flags_reg,
  output wire logic [15:0]     stack_pointer
);

  // Returns {half carry, overflow, carry, result}; carry is a borrow when subtracting
  function automatic logic [10:0] arith(input logic [7:0] a, input logic [7:0] b,
                                        input logic cin, input logic sub);
    logic [8:0] s;
    logic       h;
    logic       v;
    s = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~s[3]) | (~s[3] & a[3]);
      v = (a[7] & b[7] & ~s[7]) | (~a[7] & ~b[7] & s[7]);
    end
    return {h, v, s[8], s[7:0]};
  endfunction

  cas_state_type   state_r, state_nxt;
  logic [7:0]      gpr_r [32];
  logic [7:0]      status_r, status_nxt;
  logic [15:0]     sp_r, sp_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt, ir_pc_r;
  logic            ir_valid_r, ir_valid_nxt;
  logic [15:0]     ir_hold_r, ret_r, ret_nxt;
  logic [7:0]      ld_int_r;
  logic [1:0]      ld_src_r;
  logic [4:0]      ld_dst_r;

  // Decode of the word in execute; held word is used by multi-cycle states
  wire        in_exec  = (state_r == ST_EXEC);
  wire [15:0] ir       = in_exec ? pm_data : ir_hold_r;
  wire [3:0]  op       = ir[15:12];
  wire [3:0]  msub     = ir[6:3];
  wire [2:0]  bsel     = ir[2:0];
  wire        use_imm  = (op[3:2] == 2'b10);
  wire [4:0]  dst      = use_imm ? {1'b1, ir[11:8]} : ir[11:7];
  wire [7:0]  opa      = gpr_r[dst];
  wire [7:0]  opb      = use_imm ? ir[7:0] : gpr_r[ir[6:2]];
  wire        is_misc  = (op == OP_MISC);
  wire        is_mem   = (op == OP_MEM) && !ir[3];
  wire        is_lpm   = (op == OP_MEM) && ir[3];
  wire        is_io    = (op == OP_IO);
  wire        is_call  = is_misc && (msub == MS_CALL);
  wire        is_ret   = is_misc && ((msub == MS_RET) || (msub == MS_IRET));
  wire        is_store = (is_mem || is_io) && ir[6];
  wire        is_load  = (is_mem || is_io) && !ir[6];

  // Lowest pending index has the lowest vector and therefore wins
  logic [7:0] irq_sel;
  always_comb begin
    irq_sel = 8'h00;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_sel = 8'(i);
      end
    end
  end
  wire irq_take = in_exec && ir_valid_r && status_r[FLG_I] && (|irq_req);
  wire exec_ok  = in_exec && ir_valid_r && !irq_take;

  wire [4:0]  ptr_idx  = PTR_X_LO + {2'b00, ir[5:4], 1'b0};
  wire [15:0] ptr_val  = {gpr_r[ptr_idx + 5'd1], gpr_r[ptr_idx]};
  wire [15:0] zptr     = {gpr_r[PTR_Z_LO + 5'd1], gpr_r[PTR_Z_LO]};
  wire        post_inc = (is_mem || is_lpm) && ir[2];

  wire [15:0] daddr    = is_io ? (IO_BASE + {10'h000, ir[5:0]}) : ptr_val;
  wire [15:0] io_rel   = daddr - IO_BASE;
  wire [5:0]  io_off   = io_rel[5:0];
  wire        in_reg   = (daddr < IO_BASE);
  wire        in_io    = !in_reg && (daddr < SRAM_BASE);
  wire        in_sram  = !in_reg && !in_io;
  wire        int_io   = in_io && ((io_off == IO_SPL) || (io_off == IO_SPH) ||
                                   (io_off == IO_STATUS));
  wire        d_wr     = exec_ok && is_store;
  wire        d_rd     = exec_ok && is_load;
  wire [7:0]  st_data  = gpr_r[ir[11:7]];

  function automatic logic [7:0] int_read(input logic [5:0] off, input logic [15:0] sp,
                                          input logic [7:0] st);
    case (off)
      IO_SPL:    return sp[7:0];
      IO_SPH:    return sp[15:8];
      IO_STATUS: return st;
      default:   return 8'h00;
    endcase
  endfunction

  wire [7:0] ld_int_val = in_reg ? gpr_r[daddr[4:0]] : int_read(io_off, sp_r, status_r);

  // return address goes to SRAM stack
  wire stk_push = (state_r == ST_PUSH_L) || (state_r == ST_PUSH_H);
  wire stk_pop  = (state_r == ST_POP_H) || (state_r == ST_POP_L);
  wire [15:0] sp_up = sp_r + 16'h0001;
  assign dm_addr  = stk_push ? sp_r : (stk_pop ? sp_up : daddr);
  assign dm_wdata = (state_r == ST_PUSH_L) ? ret_r[7:0] :
                    ((state_r == ST_PUSH_H) ? ret_r[15:8] : st_data);
  assign dm_we    = stk_push || (d_wr && in_sram);
  assign dm_re    = stk_pop || (d_rd && in_sram);
  assign io_addr  = io_off;
  assign io_wdata = st_data;
  assign io_we    = d_wr && in_io && !int_io;
  assign io_re    = d_rd && in_io && !int_io;
  assign pm_addr  = (state_r == ST_LPM_A) ? zptr[PC_W:1] : pc_r;

  // ALU; N and Z follow the result only where up_vnz is set, the rest per operation
  logic [7:0]  res;
  logic [10:0] ar;
  logic        rf_alu, f_h, f_v, f_c, up_h, up_vnz, up_c;
  always_comb begin
    res    = opa;
    ar     = arith(opa, opb, 1'b0, 1'b0);
    rf_alu = 1'b0;
    f_h    = ar[10];
    f_v    = 1'b0;
    f_c    = ar[8];
    up_h   = 1'b0;
    up_vnz = 1'b0;
    up_c   = 1'b0;
    case (op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_SUBI: begin
        ar     = arith(opa, opb, op[0] & status_r[FLG_C], op[1] | op[3]);
        res    = ar[7:0];
        f_h    = ar[10];
        f_v    = ar[9];
        f_c    = ar[8];
        rf_alu = 1'b1;
        up_h   = 1'b1;
        up_vnz = 1'b1;
        up_c   = 1'b1;
      end
      OP_AND, OP_ANDI, OP_OR, OP_ORI, OP_EOR: begin
        res    = (op == OP_OR || op == OP_ORI) ? (opa | opb) :
                 ((op == OP_EOR) ? (opa ^ opb) : (opa & opb));
        rf_alu = 1'b1;
        up_vnz = 1'b1;
      end
      OP_MOV, OP_LDI: begin
        res    = opb;
        rf_alu = 1'b1;
      end
      OP_MISC: begin
        case (msub)
          MS_COM: begin
            res = ~opa;
            f_c = 1'b1;
            {rf_alu, up_vnz, up_c} = 3'b111;
          end
          MS_NEG: begin
            ar  = arith(8'h00, opa, 1'b0, 1'b1);
            res = ar[7:0];
            {f_h, f_v, f_c} = {ar[10], ar[9], ar[8]};
            {rf_alu, up_h, up_vnz, up_c} = 4'hf;
          end
          MS_INC, MS_DEC: begin
            ar  = arith(opa, 8'h01, 1'b0, msub[0]);
            res = ar[7:0];
            f_v = ar[9];
            {rf_alu, up_vnz} = 2'b11;
          end
          MS_LSR, MS_ROR, MS_ASR: begin
            res = {(msub == MS_ROR) ? status_r[FLG_C] :
                   ((msub == MS_ASR) ? opa[7] : 1'b0), opa[7:1]};
            f_c = opa[0];
            f_v = res[7] ^ opa[0];
            {rf_alu, up_vnz, up_c} = 3'b111;
          end
          MS_SWAP: begin
            res    = {opa[3:0], opa[7:4]};
            rf_alu = 1'b1;
          end
          // bit load from the copy store
          MS_BLOAD: begin
            res          = opa;
            res[bsel]    = status_r[FLG_T];
            rf_alu       = 1'b1;
          end
          default: begin
            res = opa;
          end
        endcase
      end
      default: begin
        res = opa;
      end
    endcase
  end

  // nothing here saves status on entry or restores it on return
  always_comb begin
    status_nxt = status_r;
    if (exec_ok) begin
      if (up_vnz) begin
        status_nxt[FLG_V] = f_v;
        status_nxt[FLG_N] = res[7];
        status_nxt[FLG_Z] = (res == 8'h00);
      end
      if (up_h) begin
        status_nxt[FLG_H] = f_h;
      end
      if (up_c) begin
        status_nxt[FLG_C] = f_c;
      end
      if (is_misc) begin
        case (msub)
          MS_GION:   status_nxt[FLG_I] = 1'b1;
          MS_GIOFF:  status_nxt[FLG_I] = 1'b0;
          MS_IRET:   status_nxt[FLG_I] = 1'b1;
          // bit store into the copy store
          MS_BSTORE: status_nxt[FLG_T] = opa[bsel];
          default: status_nxt[FLG_T] = status_r[FLG_T];
        endcase
      end
      if (d_wr && in_io && io_off == IO_STATUS) begin
        status_nxt = st_data;
      end
    end
    if (irq_take) begin
      status_nxt[FLG_I] = 1'b0;
    end
    if (hst_wr && hst_addr == 8'(IO_BASE) + 8'(IO_STATUS)) begin
      status_nxt = hst_wdata;
    end
    // sign is derived, never stored apart
    status_nxt[FLG_S] = status_nxt[FLG_N] ^ status_nxt[FLG_V];
  end

  always_comb begin
    sp_nxt = sp_r;
    if (stk_push) begin
      sp_nxt = sp_r - 16'h0001;
    end else if (stk_pop) begin
      sp_nxt = sp_up;
    end else if (d_wr && in_io && io_off == IO_SPL) begin
      sp_nxt[7:0] = st_data;
    end else if (d_wr && in_io && io_off == IO_SPH) begin
      sp_nxt[15:8] = st_data;
    end
    if (hst_wr && hst_addr == 8'(IO_BASE) + 8'(IO_SPL)) begin
      sp_nxt[7:0] = hst_wdata;
    end
    if (hst_wr && hst_addr == 8'(IO_BASE) + 8'(IO_SPH)) begin
      sp_nxt[15:8] = hst_wdata;
    end
  end

  // Branch on one status bit, relative to the word after the branch
  wire             br_taken = (status_r[ir[11:9]] == ir[8]);
  wire [PC_W-1:0]  br_tgt   = ir_pc_r + {{(PC_W - 8){ir[7]}}, ir[7:0]} + PC_W'(1);
  wire [PC_W-1:0]  pc_inc   = pc_r + PC_W'(1);

  // sequencing keeps one fetch in flight behind execute
  always_comb begin
    state_nxt    = state_r;
    pc_nxt       = pc_r;
    ir_valid_nxt = 1'b0;
    ret_nxt      = ret_r;
    case (state_r)
      ST_EXEC: begin
        if (irq_take) begin
          ret_nxt   = 16'(ir_pc_r);
          pc_nxt    = PC_W'(irq_sel + 8'h01);
          state_nxt = ST_PUSH_L;
        end else if (!ir_valid_r) begin
          pc_nxt       = pc_inc;
          ir_valid_nxt = 1'b1;
        end else if (op == OP_BR && br_taken) begin
          pc_nxt = br_tgt;
        end else if (is_call) begin
          // second word is taken as the call target
          pc_nxt    = pc_inc;
          state_nxt = ST_CALL_T;
        end else if (is_ret) begin
          state_nxt = ST_POP_H;
        end else if (is_lpm) begin
          state_nxt = ST_LPM_A;
        end else if (is_load) begin
          state_nxt = ST_LD_W;
        end else begin
          pc_nxt       = pc_inc;
          ir_valid_nxt = 1'b1;
        end
      end
      ST_CALL_T: begin
        ret_nxt   = 16'(pc_r);
        pc_nxt    = pm_data[PC_W-1:0];
        state_nxt = ST_PUSH_L;
      end
      ST_PUSH_L: state_nxt = ST_PUSH_H;
      ST_POP_H:  state_nxt = ST_POP_L;
      ST_POP_L: begin
        ret_nxt[15:8] = dm_rdata;
        state_nxt     = ST_POP_D;
      end
      ST_POP_D: begin
        pc_nxt    = PC_W'({ret_r[15:8], dm_rdata});
        state_nxt = ST_POP_F;
      end
      ST_LPM_A:  state_nxt = ST_LPM_D;
      ST_PUSH_H, ST_POP_F, ST_LPM_D, ST_LD_W: begin
        pc_nxt       = pc_inc;
        ir_valid_nxt = 1'b1;
        state_nxt    = ST_EXEC;
      end
      default: state_nxt = ST_EXEC;
    endcase
  end

  // single write port, selected per source
  logic       rf_we;
  logic [4:0] rf_idx;
  logic [7:0] rf_val;
  wire  [7:0] lpm_byte = zptr[0] ? pm_data[15:8] : pm_data[7:0];
  wire  [7:0] ld_val   = (ld_src_r == LD_IO) ? io_rdata :
                         ((ld_src_r == LD_SRAM) ? dm_rdata : ld_int_r);
  always_comb begin
    rf_we  = 1'b0;
    rf_idx = dst;
    rf_val = res;
    if (state_r == ST_LD_W) begin
      {rf_we, rf_idx, rf_val} = {1'b1, ld_dst_r, ld_val};
    end else if (state_r == ST_LPM_D) begin
      {rf_we, rf_idx, rf_val} = {1'b1, ir_hold_r[11:7], lpm_byte};
    end else if (d_wr && in_reg) begin
      {rf_we, rf_idx, rf_val} = {1'b1, daddr[4:0], st_data};
    end else begin
      // result written back in the same cycle
      rf_we = exec_ok && rf_alu;
    end
  end
  wire       pw_mem  = exec_ok && is_mem && post_inc;
  wire       pw_lpm  = (state_r == ST_LPM_D) && ir_hold_r[2];
  wire [4:0] pw_idx  = pw_lpm ? PTR_Z_LO : ptr_idx;
  wire [15:0] pw_val = (pw_lpm ? zptr : ptr_val) + 16'h0001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        gpr_r[i] <= 8'h00;
      end
    end else begin
      if (rf_we) begin
        gpr_r[rf_idx] <= rf_val;
      end
      // pointer post-increment as one 16-bit write
      if (pw_mem || pw_lpm) begin
        gpr_r[pw_idx]        <= pw_val[7:0];
        gpr_r[pw_idx + 5'd1] <= pw_val[15:8];
      end
      // Host writes win over the core in the same cycle
      if (hst_wr && hst_addr < 8'(IO_BASE)) begin
        gpr_r[hst_addr[4:0]] <= hst_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_EXEC;
      pc_r       <= '0;
      ir_pc_r    <= '0;
      ir_valid_r <= 1'b0;
      ir_hold_r  <= 16'h0000;
      ret_r      <= 16'h0000;
      status_r   <= STATUS_RST;
      sp_r       <= STK_RST;
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      ir_pc_r    <= pc_r;
      ir_valid_r <= ir_valid_nxt;
      ir_hold_r  <= ir;
      ret_r      <= ret_nxt;
      status_r   <= status_nxt;
      sp_r       <= sp_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_int_r <= 8'h00;
      ld_src_r <= LD_INT;
      ld_dst_r <= 5'h00;
    end else if (d_rd) begin
      ld_int_r <= ld_int_val;
      ld_src_r <= in_sram ? LD_SRAM : ((in_io && !int_io) ? LD_IO : LD_INT);
      ld_dst_r <= ir[11:7];
    end
  end

  // Ack is late by one cycle; the cleared enable prevents a second take meanwhile
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack   <= 1'b0;
      irq_id    <= 8'h00;
      hst_rdata <= 8'h00;
    end else begin
      irq_ack   <= irq_take;
      irq_id    <= irq_take ? irq_sel : irq_id;
      hst_rdata <= !hst_rd ? 8'h00 :
                   ((hst_addr < 8'(IO_BASE)) ? gpr_r[hst_addr[4:0]] :
                   int_read(6'(hst_addr - 8'(IO_BASE)), sp_r, status_r));
    end
  end

  assign status_flags_reg = status_r;
  assign stack_pointer    = sp_r;

endmodule

// *** dv/cas_mem_model.sv ***
`timescale 1ns/1ps
module cas_mem_model
  import cas_pkg::*;
#(
  parameter int PC_W = 11
) (
  input  wire logic            clk,
  input  wire logic [PC_W-1:0] pm_addr,
  output logic      [15:0]     pm_data,
  input  wire logic [15:0]     dm_addr,
  input  wire logic [7:0]      dm_wdata,
  input  wire logic            dm_we,
  input  wire logic            dm_re,
  output logic      [7:0]      dm_rdata,
  input  wire logic [5:0]      io_addr,
  input  wire logic [7:0]      io_wdata,
  input  wire logic            io_we,
  input  wire logic            io_re,
  output logic      [7:0]      io_rdata
);
  logic [15:0] rom [2**PC_W];
  logic [7:0]  sram [256];
  logic [7:0]  io_mem [64];

  initial begin
    pm_data = 16'h0000;
    dm_rdata = 8'h00;
    io_rdata = 8'h00;
  end

  always @(posedge clk) begin
    pm_data <= rom[pm_addr];
    if (dm_we) begin
      sram[dm_addr[7:0]] <= dm_wdata;
    end
    if (io_we) begin
      io_mem[io_addr] <= io_wdata;
    end
  end

  // Read data stand one cycle; a toggling pattern after it exposes late sampling
  always @(posedge clk) begin
    dm_rdata <= dm_re ? sram[dm_addr[7:0]] : ~dm_rdata;
    io_rdata <= io_re ? io_mem[io_addr] : ~io_rdata;
  end
endmodule

// *** dv/cas_core_sva.sv ***
`timescale 1ns/1ps
module cas_core_sva
  import cas_pkg::*;
#(
  parameter int NIRQ = 16
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic [15:0]     dm_addr,
  input wire logic            dm_we,
  input wire logic            dm_re,
  input wire logic [5:0]      io_addr,
  input wire logic            io_we,
  input wire logic            io_re,
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic            irq_ack,
  input wire logic [7:0]      irq_id,
  input wire logic [7:0]      hst_addr,
  input wire logic [7:0]      hst_wdata,
  input wire logic            hst_wr,
  input wire logic            hst_rd,
  input wire logic [7:0]      hst_rdata,
  input wire logic [7:0]      status_flags_reg,
  input wire logic [15:0]     stack_pointer
);
  logic [NIRQ-1:0] req_d;

  always_ff @(posedge clk) begin
    req_d <= irq_req;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_push_pair;
    dm_we ##1 (dm_we && dm_addr == $past(dm_addr) - 16'h0001);
  endsequence

  a_reset_zero: assert property (
    $rose(rst_n) |-> status_flags_reg == STATUS_RST && stack_pointer == STK_RST)
    else $error("status or stack pointer not zero after reset");
  a_sign_xor: assert property (
    status_flags_reg[FLG_S] == (status_flags_reg[FLG_N] ^ status_flags_reg[FLG_V]))
    else $error("sign flag differs from negative xor overflow");
  a_irq_gated: assert property (
    irq_ack |-> $past(status_flags_reg[FLG_I]))
    else $error("interrupt taken with global enable clear");
  a_irq_clears_i: assert property (
    irq_ack && !$past(hst_wr) |-> !status_flags_reg[FLG_I])
    else $error("global enable not cleared on interrupt entry");
  a_irq_lowest_wins: assert property (
    irq_ack |-> req_d[irq_id] && (req_d & ~({NIRQ{1'b1}} << irq_id)) == '0)
    else $error("interrupt taken is not the lowest pending source");
  a_irq_push_pair: assert property (
    irq_ack |-> s_push_pair)
    else $error("return address not pushed as two descending bytes");
  a_irq_sp_drop: assert property (
    irq_ack |-> ##2 stack_pointer == $past(stack_pointer, 3) - 16'h0002)
    else $error("stack pointer not lowered by two on interrupt");
  a_sp_low_read: assert property (
    hst_rd && hst_addr == 8'h5d |=> hst_rdata == $past(stack_pointer[7:0]))
    else $error("stack pointer low byte read wrong");
  a_status_host_wr: assert property (
    hst_wr && hst_addr == 8'h5f |=> status_flags_reg ==
      {$past(hst_wdata[7:5]), ^$past(hst_wdata[3:2]), $past(hst_wdata[3:0])})
    else $error("status write not applied with recomputed sign");
  a_io_window: assert property (
    io_we || io_re |-> io_addr < IO_SPL)
    else $error("external io access to a core-owned address");
  a_sram_window: assert property (
    dm_we || dm_re |-> dm_addr >= SRAM_BASE)
    else $error("sram access below the data memory base");
endmodule

bind cas_core cas_core_sva #(.NIRQ(NIRQ)) u_sva (
  .clk              (clk),
  .rst_n            (rst_n),
  .dm_addr          (dm_addr),
  .dm_we            (dm_we),
  .dm_re            (dm_re),
  .io_addr          (io_addr),
  .io_we            (io_we),
  .io_re            (io_re),
  .irq_req          (irq_req),
  .irq_ack          (irq_ack),
  .irq_id           (irq_id),
  .hst_addr         (hst_addr),
  .hst_wdata        (hst_wdata),
  .hst_wr           (hst_wr),
  .hst_rd           (hst_rd),
  .hst_rdata        (hst_rdata),
  .status_flags_reg (status_flags_reg),
  .stack_pointer    (stack_pointer)
);

// *** dv/cas_core_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module cas_core_tb_top
  import cas_pkg::*;
;
  logic        clk, rst_n, dm_we, dm_re, io_we, io_re, irq_ack, hst_wr, hst_rd;
  logic [10:0] pm_addr;
  logic [15:0] pm_data, dm_addr, irq_req, stack_pointer;
  logic [7:0]  dm_wdata, dm_rdata, io_wdata, io_rdata, irq_id;
  logic [7:0]  hst_addr, hst_wdata, hst_rdata, status_flags_reg;
  logic [5:0]  io_addr;
  int          err_count, samples_checked, i;
  // Words 17..33: flag-producing ALU sequence, bit copy, io stores, idle loop
  localparam logic [15:0] PROG [17] = '{16'hb07f, 16'hb101, 16'h0844, 16'hf93f,
    16'h2840, 16'hf9bf, 16'hc8c0, 16'hc84f, 16'hf845, 16'hfa3f, 16'hc050,
    16'hfabf, 16'hc058, 16'hba26, 16'hbb00, 16'he8c0, 16'hdeff};

  cas_core uut (.clk(clk), .rst_n(rst_n), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata), .irq_req(irq_req), .irq_ack(irq_ack),
    .irq_id(irq_id), .hst_addr(hst_addr), .hst_wdata(hst_wdata), .hst_wr(hst_wr),
    .hst_rd(hst_rd), .hst_rdata(hst_rdata), .status_flags_reg(status_flags_reg),
    .stack_pointer(stack_pointer));

  cas_mem_model mem (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
    .dm_rdata(dm_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata(io_rdata));

  always #4 clk = ~clk;

  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hst_wr <= 1'b1;
    hst_addr <= a;
    hst_wdata <= d;
    @(posedge clk);
    hst_wr <= 1'b0;
  endtask

  task automatic host_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    hst_rd <= 1'b1;
    hst_addr <= a;
    @(posedge clk);
    hst_rd <= 1'b0;
    #1;
    `CHK(hst_rdata, exp)
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    irq_req = '0;
    hst_addr = 8'h00;
    hst_wdata = 8'h00;
    hst_wr = 1'b0;
    hst_rd = 1'b0;
    err_count = 0;
    samples_checked = 0;
    for (i = 0; i < 2048; i++) begin
      mem.rom[i] = 16'h7000;
    end
    mem.rom[0] = 16'hde10;
    mem.rom[3] = 16'h2000;
    mem.rom[4] = 16'hc068;
    for (i = 0; i < 17; i++) begin
      mem.rom[17+i] = PROG[i];
    end
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    host_chk(8'h5f, STATUS_RST);
    host_chk(8'h5d, STK_RST[7:0]);
    host_chk(8'h5e, STK_RST[15:8]);
    $display("test reset_values done");
    repeat (60) @(posedge clk);
    host_chk(8'h10, 8'h80);
    host_chk(8'h11, 8'h01);
    host_chk(8'h12, 8'h2c);
    host_chk(8'h13, 8'h02);
    host_chk(8'h14, 8'h42);
    host_chk(8'h15, 8'hc2);
    host_chk(8'h1a, 8'h26);
    host_chk(8'h5f, 8'h42);
    `CHK(mem.io_mem[5], 8'h80)
    `CHK(mem.io_mem[6], 8'h01)
    $display("test alu_program done");
    host_wr(8'h00, 8'h5a);
    host_chk(8'h00, 8'h5a);
    host_chk(8'h80, 8'h00);
    host_wr(8'h5f, 8'h1c);
    host_chk(8'h5f, 8'h0c);
    // the host port sets the stack before enabling interrupts
    host_wr(8'h5d, 8'hff);
    host_wr(8'h5e, 8'h00);
    host_chk(8'h5d, 8'hff);
    $display("test host_port done");
    @(posedge clk);
    irq_req <= 16'h0024;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      `CHK(irq_ack, 1'b0)
    end
    host_wr(8'h5f, 8'h81);
    for (i = 0; i < 20 && irq_ack !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (irq_ack !== 1'b1) begin
      err_count++;
      summarize();
    end
    `CHK(irq_id, 8'h02)
    `CHK(status_flags_reg[FLG_I], 1'b0)
    @(posedge clk);
    irq_req <= '0;
    repeat (20) @(posedge clk);
    #1;
    `CHK(status_flags_reg, 8'h82)
    `CHK(stack_pointer, 16'h00ff)
    `CHK(mem.sram[8'hfe], 8'h00)
    `CHK(mem.sram[8'hff] inside {8'h21, 8'h22}, 1'b1)
    $display("test interrupt done");
    summarize();
  end
endmodule
